// ===== verilog/hrc_repeater.v
// Hub repeater control state machine with connectivity and port error outputs.
`timescale 1ns/1ps
`include "hrc_defs.vh"
// Overview of operation
// - Bus reset forces wait for upstream start.
// - Past EOF1, any-start wait narrows upstream.
// - EOF2 ends upward repeat to upstream wait.
// - Upstream end unlocked returns to upstream wait.
// - Upstream wait ignores downstream, no connectivity.
// - Upstream start in waits begins downward repeat.
// - Receiver resume enters downward repeat.
// - Downward repeat connects and transmits enabled ports.
// - Downstream end in upward repeat waits any.
// - Upstream end locked returns to any wait.
// - Receiver suspend enters any-start wait, except from upward repeat.
// - Any-start wait watches all enabled starts.
// - Downstream start enters upward repeat from port.
// - Upward repeat drives upstream, transmitter active.
// - EOF2 in upward repeat disables babbling port.
// - EOF1 upward sends full-speed end, stays.
// - EOF2 upstream wait, non-idle port errors.
// - High-speed end is OR of three.
// - Transmit end on idle-J; upstream end received.
// - EOF levels held; lock reports synchronisation.
// - Starts fire on idle-to-K after validation.
// - High-speed end waits for last buffered bit.
// - Full-speed end waits one J bit.
module hrc_repeater #(
	parameter PORTS = `HRC_PORTS,
	parameter FS_BIT_CYCLES = `HRC_FS_BIT_CYCLES,
	parameter EVT_DEPTH = `HRC_FIFO_DEPTH
) (
	input wire core_clk,
	input wire reset_n,
	input wire high_speed,
	input wire rx_bus_reset,
	input wire rx_suspend,
	input wire rx_resume,
	input wire eof1,
	input wire eof2,
	input wire timer_lock,
	input wire buffer_drained,
	input wire buffer_last_bit_sent,
	input wire send_resume_end,
	input wire interval_end,
	input wire receiver_interval_end,
	input wire send_idle_j,
	input wire up_eop_seen,
	input wire up_idle_to_k,
	input wire up_hs_packet_start,
	input wire [PORTS-1:0] port_enabled,
	input wire [PORTS-1:0] port_idle,
	input wire [PORTS-1:0] port_idle_to_k,
	input wire [PORTS-1:0] port_hs_packet_start,
	output reg [3:0] repeater_state,
	output reg connect_down,
	output reg connect_up,
	output reg [PORTS-1:0] connect_port,
	output reg [PORTS-1:0] port_transmit,
	output reg up_tx_active,
	output reg up_tx_fs_eop,
	output reg [PORTS-1:0] port_disable,
	output reg [PORTS-1:0] port_error,
	output wire evt_valid,
	input wire evt_ready,
	output wire [`HRC_EVT_WIDTH-1:0] evt_data,
	output wire evt_overflow
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam NIN = 16;
	wire [NIN-1:0] raw_in;
	reg [NIN-1:0] sync_a;
	reg [NIN-1:0] sync_b;
	reg [PORTS-1:0] pen_a, pen_b, pidle_a, pidle_b, pk_a, pk_b, phs_a, phs_b;
	assign raw_in = {up_hs_packet_start, high_speed, rx_bus_reset, rx_suspend, rx_resume,
		eof1, eof2, timer_lock, buffer_drained, buffer_last_bit_sent, send_resume_end,
		interval_end, receiver_interval_end, send_idle_j, up_eop_seen, up_idle_to_k};
	always @(posedge core_clk) begin
		if (!reset_n) begin
			sync_a <= {NIN{1'b0}};
			sync_b <= {NIN{1'b0}};
			pen_a <= {PORTS{1'b0}};
			pen_b <= {PORTS{1'b0}};
			pidle_a <= {PORTS{1'b1}};
			pidle_b <= {PORTS{1'b1}};
			pk_a <= {PORTS{1'b0}};
			pk_b <= {PORTS{1'b0}};
			phs_a <= {PORTS{1'b0}};
			phs_b <= {PORTS{1'b0}};
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			pen_a <= port_enabled;
			pen_b <= pen_a;
			pidle_a <= port_idle;
			pidle_b <= pidle_a;
			pk_a <= port_idle_to_k;
			pk_b <= pk_a;
			phs_a <= port_hs_packet_start;
			phs_b <= phs_a;
		end
	end
	wire s_hs = sync_b[14];
	wire s_reset = sync_b[13];
	wire s_susp = sync_b[12];
	wire s_resume = sync_b[11];
	wire s_eof1 = sync_b[10];
	wire s_eof2 = sync_b[9];
	wire s_lock = sync_b[8];
	wire s_drained = sync_b[7];
	wire s_lastbit = sync_b[6];
	wire s_send_resume_end = sync_b[5];
	wire s_ie = sync_b[4];
	wire s_rx_ie = sync_b[3];
	wire s_idle_j = sync_b[2];
	wire s_up_eop = sync_b[1];
	wire s_up_k = sync_b[0] || sync_b[15];
	// The upstream start raw input is a level; only its rise is an event.
	reg up_k_d;
	reg idle_j_d;
	reg [PORTS-1:0] pk_d;
	reg resume_d;
	reg susp_d;
	reg eof1_d;
	reg eof2_d;
	// ----------------------------------------
	// Event formation
	// ----------------------------------------
	// High-speed end event, held until the last buffered bit is out.
	wire eor_exit = s_send_resume_end && s_ie;
	wire hs_packet_end_raw = s_drained || eor_exit || s_rx_ie;
	reg hs_end_pending;
	wire hs_packet_end = (hs_packet_end_raw || hs_end_pending) && s_lastbit;
	// Full-speed end: wait for J to be driven for a full bit time.
	reg [7:0] j_count;
	wire fs_end_done = (j_count == FS_BIT_CYCLES[7:0]);
	wire transmit_packet_end = s_hs ? hs_packet_end : fs_end_done;
	wire upstream_packet_end = s_hs ? (hs_packet_end && s_up_eop) : (fs_end_done && s_up_eop);
	wire start_from_above = s_up_k && !up_k_d;
	wire [PORTS-1:0] below_level = pk_b | phs_b;
	wire [PORTS-1:0] below_start = below_level & ~pk_d & pen_b;
	wire start_from_below = |below_start;
	wire resume_rise = s_resume && !resume_d;
	wire susp_rise = s_susp && !susp_d;
	wire eof1_rise = s_eof1 && !eof1_d;
	wire eof2_rise = s_eof2 && !eof2_d;
	// Lowest numbered port wins when several start together.
	reg [PORTS-1:0] first_below;
	integer i;
	always @* begin
		first_below = {PORTS{1'b0}};
		for (i = PORTS - 1; i >= 0; i = i - 1) begin
			if (below_start[i]) begin
				first_below = {PORTS{1'b0}};
				first_below[i] = 1'b1;
			end
		end
	end
	// ----------------------------------------
	// State machine
	// ----------------------------------------
	localparam ST_WU = `HRC_ST_WAIT_UP_START;
	localparam ST_RD = `HRC_ST_REPEAT_DOWNWARD;
	localparam ST_WA = `HRC_ST_WAIT_ANY_START;
	localparam ST_RU = `HRC_ST_REPEAT_UPWARD;
	reg [3:0] next_state;
	always @* begin
		next_state = repeater_state;
		case (repeater_state)
			ST_WU: begin
				// Downstream activity is never looked at here.
				if (resume_rise || start_from_above) begin
					next_state = ST_RD;
				end else if (susp_rise) begin
					next_state = ST_WA;
				end
			end
			ST_RD: begin
				if (susp_rise) begin
					next_state = ST_WA;
				end else if (upstream_packet_end) begin
					next_state = s_lock ? ST_WA : ST_WU;
				end
			end
			ST_WA: begin
				if (resume_rise || start_from_above) begin
					next_state = ST_RD;
				end else if (s_eof1) begin
					next_state = ST_WU;
				end else if (start_from_below) begin
					next_state = ST_RU;
				end
			end
			ST_RU: begin
				if (s_eof2) begin
					next_state = ST_WU;
				end else if (resume_rise) begin
					next_state = ST_RD;
				end else if (transmit_packet_end) begin
					next_state = ST_WA;
				end
			end
			default: begin
				next_state = ST_WU;
			end
		endcase
		if (s_reset) begin
			next_state = ST_WU;
		end
	end
	// ----------------------------------------
	// Registered state, connectivity and errors
	// ----------------------------------------
	wire enter_rd = (next_state == ST_RD) && (repeater_state != ST_RD);
	wire enter_ru = (next_state == ST_RU) && (repeater_state != ST_RU);
	wire babble = (repeater_state == ST_RU) && eof2_rise;
	wire [PORTS-1:0] idle_err = (repeater_state == ST_WU && eof2_rise) ?
		(pen_b & ~pidle_b) : {PORTS{1'b0}};
	always @(posedge core_clk) begin
		if (!reset_n) begin
			repeater_state <= ST_WU;
			connect_down <= 1'b0;
			connect_up <= 1'b0;
			connect_port <= {PORTS{1'b0}};
			port_transmit <= {PORTS{1'b0}};
			up_tx_active <= 1'b0;
			up_tx_fs_eop <= 1'b0;
			port_disable <= {PORTS{1'b0}};
			port_error <= {PORTS{1'b0}};
			hs_end_pending <= 1'b0;
			j_count <= 8'h00;
			up_k_d <= 1'b0;
			idle_j_d <= 1'b0;
			pk_d <= {PORTS{1'b0}};
			resume_d <= 1'b0;
			susp_d <= 1'b0;
			eof1_d <= 1'b0;
			eof2_d <= 1'b0;
		end else begin
			repeater_state <= next_state;
			up_k_d <= s_up_k;
			idle_j_d <= s_idle_j;
			pk_d <= below_level;
			resume_d <= s_resume;
			susp_d <= s_susp;
			eof1_d <= s_eof1;
			eof2_d <= s_eof2;
			connect_down <= (next_state == ST_RD);
			connect_up <= (next_state == ST_RU);
			if (enter_ru) begin
				connect_port <= first_below;
			end else if (next_state != ST_RU) begin
				connect_port <= {PORTS{1'b0}};
			end
			if (enter_rd) begin
				port_transmit <= pen_b;
			end else if (next_state != ST_RD) begin
				port_transmit <= {PORTS{1'b0}};
			end
			up_tx_active <= (next_state == ST_RU);
			// The host's hub would disable us if we still drove at EOF2.
			if (repeater_state == ST_RU && eof1_rise) begin
				up_tx_fs_eop <= 1'b1;
			end else if (next_state != ST_RU) begin
				up_tx_fs_eop <= 1'b0;
			end
			if (babble) begin
				port_disable <= port_disable | connect_port;
			end
			port_error <= port_error | idle_err | (babble ? connect_port : {PORTS{1'b0}});
			// Ports that software has disabled lose their sticky flags.
			if (!(babble) && !(|idle_err)) begin
				port_disable <= port_disable & pen_b;
				port_error <= port_error & pen_b;
			end
			if (hs_packet_end) begin
				hs_end_pending <= 1'b0;
			end else if (hs_packet_end_raw) begin
				hs_end_pending <= 1'b1;
			end
			if (s_idle_j && !idle_j_d) begin
				j_count <= 8'h01;
			end else if (s_idle_j && j_count != 8'h00 && !fs_end_done) begin
				j_count <= j_count + 8'h01;
			end else begin
				j_count <= 8'h00;
			end
		end
	end
	// ----------------------------------------
	// Event log of state changes
	// ----------------------------------------
	// A full log drops entries rather than stalling the repeater; the drop is flagged.
	wire log_ready;
	wire log_valid = (next_state != repeater_state);
	reg overflow;
	assign evt_overflow = overflow;
	always @(posedge core_clk) begin
		if (!reset_n) begin
			overflow <= 1'b0;
		end else if (log_valid && !log_ready) begin
			overflow <= 1'b1;
		end
	end
	hrc_fifo #(
		.WIDTH(`HRC_EVT_WIDTH),
		.DEPTH(EVT_DEPTH),
		.AW(4)
	) u_log (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(log_valid),
		.in_ready(log_ready),
		.in_data({repeater_state, next_state}),
		.out_valid(evt_valid),
		.out_ready(evt_ready),
		.out_data(evt_data)
	);
endmodule

module hrc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk,
	input wire reset_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	reg have_out;
	wire do_wr;
	wire do_rd;
	wire load_out;
	wire [AW+1:0] fill;
	// The output register is one of the DEPTH places, so the log never holds more.
	assign fill = {1'b0, count} + {{(AW+1){1'b0}}, have_out};
	assign in_ready = (fill < DEPTH[AW+1:0]);
	assign do_wr = in_valid && in_ready;
	assign load_out = (count != {(AW+1){1'b0}}) && (!have_out || out_ready);
	assign do_rd = load_out;
	assign out_valid = have_out;
	always @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			have_out <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (do_wr) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				out_data <= mem[rd_ptr];
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
			if (load_out) begin
				have_out <= 1'b1;
			end else if (out_ready) begin
				have_out <= 1'b0;
			end
		end
	end
endmodule

// ===== verilog/hrc_defs.vh
// Shared constants of the hub repeater control block.
`ifndef HRC_DEFS_VH
`define HRC_DEFS_VH
// ----------------------------------------
// Repeater states, one-hot
// ----------------------------------------
`define HRC_ST_WAIT_UP_START 4'h1
`define HRC_ST_REPEAT_DOWNWARD 4'h2
`define HRC_ST_WAIT_ANY_START 4'h4
`define HRC_ST_REPEAT_UPWARD 4'h8
// ----------------------------------------
// Defaults and timing
// ----------------------------------------
`define HRC_PORTS 4
`define HRC_EVT_WIDTH 8
`define HRC_FIFO_DEPTH 16
`define HRC_FS_BIT_CYCLES 4
`define HRC_RESET_PORT_SEL 4'h0
`endif

// ===== verilog/hrc_fifo.v
// The event-log FIFO module is kept with the repeater logic in hrc_repeater.v.

// ===== verification/hrc_repeater_props.sv
// Concurrent checks on the ports of the hub repeater control block.
`timescale 1ns/1ps
module hrc_repeater_props #(
	parameter PORTS = 4
) (
	input wire core_clk,
	input wire reset_n,
	input wire rx_bus_reset,
	input wire eof1,
	input wire eof2,
	input wire [PORTS-1:0] port_enabled,
	input wire [PORTS-1:0] port_idle,
	input wire [3:0] repeater_state,
	input wire connect_down,
	input wire connect_up,
	input wire [PORTS-1:0] connect_port,
	input wire up_tx_active,
	input wire up_tx_fs_eop,
	input wire [PORTS-1:0] port_disable,
	input wire [PORTS-1:0] port_error
);
	// Inputs pass two sync stages, so the windows below allow for that lag.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	a_reset_start: assert property ($rose(reset_n) |-> repeater_state == 4'h1 && connect_port == 0)
		else $error("repeater not idle after reset");
	a_state_onehot: assert property ($onehot(repeater_state))
		else $error("repeater state not one-hot");
	a_bus_reset_wins: assert property (rx_bus_reset [*5] |-> repeater_state == 4'h1)
		else $error("bus reset did not force upstream wait");
	a_waits_no_link: assert property ((repeater_state == 4'h1 || repeater_state == 4'h4) |-> !connect_down && !connect_up && connect_port == 0)
		else $error("link up in a wait state");
	a_down_link: assert property (repeater_state == 4'h2 |-> connect_down && !connect_up)
		else $error("downward repeat without downward link");
	a_up_link: assert property (repeater_state == 4'h8 |-> connect_up && up_tx_active && $onehot(connect_port))
		else $error("upward repeat without upward link");
	a_up_entry: assert property (repeater_state == 4'h8 && $past(repeater_state) != 4'h8 |-> $past(repeater_state) == 4'h4)
		else $error("upward repeat entered from wrong state");
	a_fs_eop_eof1: assert property ((repeater_state == 4'h8 && eof1) [*5] |-> up_tx_fs_eop)
		else $error("no full-speed end at eof1");
	a_babble_cut: assert property ((repeater_state == 4'h8 && eof2 && !rx_bus_reset) [*2] |-> ##[1:3] (port_disable & port_error) != 0)
		else $error("babbling port not disabled at eof2");
	a_eof2_busy_err: assert property ((repeater_state == 4'h1 && eof2 && (port_enabled & ~port_idle) != 0) [*5] |-> (port_error & port_enabled & ~port_idle) != 0)
		else $error("busy port not flagged at eof2");
endmodule
bind hrc_repeater hrc_repeater_props #(.PORTS(PORTS)) u_props (.core_clk, .reset_n, .rx_bus_reset,
	.eof1, .eof2, .port_enabled, .port_idle, .repeater_state, .connect_down, .connect_up,
	.connect_port, .up_tx_active, .up_tx_fs_eop, .port_disable, .port_error);

// ===== verification/hrc_far_end.sv
// Downstream device model: leaves idle and raises a start edge per port.
`timescale 1ns/1ps
module hrc_far_end #(
	parameter PORTS = 4
) (
	input wire core_clk,
	input wire [PORTS-1:0] talk,
	input wire slow,
	output reg [PORTS-1:0] port_idle,
	output reg [PORTS-1:0] port_idle_to_k,
	output reg [PORTS-1:0] port_hs_packet_start
);
	reg [PORTS-1:0] talk_d = 0;
	reg [PORTS-1:0] talk_q = 0;
	initial begin
		port_idle = {PORTS{1'b1}};
		port_idle_to_k = 0;
		port_hs_packet_start = 0;
	end
	// A slow device answers one cycle later than a prompt one.
	always @(posedge core_clk) begin
		talk_d <= talk;
		talk_q <= slow ? talk_d : talk;
		port_idle <= ~talk_q;
		port_idle_to_k <= talk_q;
		port_hs_packet_start <= talk_q;
	end
endmodule

// ===== verification/hrc_repeater_bench.sv
// Self-checking bench of the hub repeater control block.
`timescale 1ns/1ps
module hrc_repeater_bench;
	logic core_clk, reset_n, high_speed, rx_bus_reset, rx_suspend, rx_resume, eof1, eof2;
	logic timer_lock, buffer_drained, buffer_last_bit_sent, send_resume_end, interval_end;
	logic receiver_interval_end, send_idle_j, up_eop_seen, up_idle_to_k, up_hs_packet_start;
	logic connect_down, connect_up, up_tx_active, up_tx_fs_eop, evt_valid, evt_ready;
	logic evt_overflow, slow, hold;
	logic [3:0] port_enabled, port_idle, port_idle_to_k, port_hs_packet_start, talk, cur;
	logic [3:0] repeater_state, connect_port, port_transmit, port_disable, port_error;
	logic [7:0] evt_data;
	logic [7:0] exp_q[$];
	int err_count, samples_checked, i;
	hrc_repeater uut (.core_clk, .reset_n, .high_speed, .rx_bus_reset, .rx_suspend, .rx_resume,
		.eof1, .eof2, .timer_lock, .buffer_drained, .buffer_last_bit_sent, .send_resume_end,
		.interval_end, .receiver_interval_end, .send_idle_j, .up_eop_seen, .up_idle_to_k,
		.up_hs_packet_start, .port_enabled, .port_idle, .port_idle_to_k, .port_hs_packet_start,
		.repeater_state, .connect_down, .connect_up, .connect_port, .port_transmit,
		.up_tx_active, .up_tx_fs_eop, .port_disable, .port_error, .evt_valid, .evt_ready,
		.evt_data, .evt_overflow);
	hrc_far_end far (.core_clk, .talk, .slow, .port_idle, .port_idle_to_k, .port_hs_packet_start);
	initial begin
		core_clk = 0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		evt_ready = 0;
		void'($urandom(78384));
		forever begin
			@(posedge core_clk);
			#1 evt_ready = !hold && ($urandom % 4 != 0);
		end
	end
	task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t output %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t event %h expected %h", $time, got, exp);
		end
	endtask
	// A full log drops new words, so notes stop once sixteen are waiting.
	always @(posedge core_clk)
		if (reset_n && evt_valid && evt_ready)
			chk_word(evt_data, exp_q.size() ? exp_q.pop_front() : 8'h00);
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic move(input logic [3:0] nxt);
		if (!hold || exp_q.size() < 16)
			exp_q.push_back({cur, nxt});
		cur = nxt;
		tick(12);
		chk_out(repeater_state, nxt);
	endtask
	task automatic stay;
		tick(12);
		chk_out(repeater_state, cur);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		test_done;
	end
	initial begin
		{high_speed, rx_bus_reset, rx_suspend, rx_resume, eof1, eof2, timer_lock} = 0;
		{buffer_drained, buffer_last_bit_sent, send_resume_end, interval_end} = 0;
		{receiver_interval_end, send_idle_j, up_eop_seen, up_idle_to_k, up_hs_packet_start} = 0;
		{talk, slow, hold} = 0;
		err_count = 0;
		samples_checked = 0;
		port_enabled = 4'hB;
		cur = 4'h1;
		reset_n = 0;
		tick(8);
		reset_n = 1;
		tick(4);
		chk_out({connect_down, connect_up, up_tx_active, up_tx_fs_eop}, 4'h0);
		talk = 4'h2;
		stay;
		talk = 0;
		tick(4);
		up_idle_to_k = 1;
		move(4'h2);
		up_idle_to_k = 0;
		chk_out(port_transmit, 4'hB);
		{timer_lock, up_eop_seen, send_idle_j} = 3'b111;
		move(4'h4);
		send_idle_j = 0;
		talk = 4'h4;
		stay;
		talk = 4'h8;
		move(4'h8);
		chk_out(connect_port, 4'h8);
		talk = 0;
		{up_eop_seen, send_idle_j} = 2'b01;
		move(4'h4);
		send_idle_j = 0;
		eof1 = 1;
		move(4'h1);
		talk = 4'h1;
		tick(4);
		eof2 = 1;
		tick(12);
		chk_out(port_error, 4'h1);
		{eof1, eof2, talk} = 0;
		$display("test wait states done");
		up_hs_packet_start = 1;
		move(4'h2);
		up_hs_packet_start = 0;
		{timer_lock, up_eop_seen, send_idle_j} = 3'b011;
		move(4'h1);
		send_idle_j = 0;
		up_idle_to_k = 1;
		move(4'h2);
		up_idle_to_k = 0;
		rx_suspend = 1;
		move(4'h4);
		rx_suspend = 0;
		rx_resume = 1;
		move(4'h2);
		rx_resume = 0;
		{timer_lock, up_eop_seen, send_idle_j} = 3'b111;
		move(4'h4);
		{slow, send_idle_j, talk} = 6'b101;
		move(4'h8);
		rx_resume = 1;
		move(4'h2);
		{rx_resume, talk, send_idle_j} = 6'b1;
		move(4'h4);
		send_idle_j = 0;
		$display("test receiver states done");
		talk = 4'h2;
		move(4'h8);
		eof1 = 1;
		stay;
		chk_out({3'h0, up_tx_fs_eop}, 4'h1);
		eof2 = 1;
		move(4'h1);
		chk_out(port_disable, 4'h2);
		chk_out(port_error, 4'h3);
		{eof1, eof2, talk, port_enabled} = 0;
		tick(6);
		chk_out(port_error, 4'h0);
		port_enabled = 4'hF;
		up_idle_to_k = 1;
		move(4'h2);
		chk_out(port_transmit, 4'hF);
		{up_idle_to_k, rx_bus_reset} = 2'b01;
		move(4'h1);
		rx_bus_reset = 0;
		$display("test eof and bus reset done");
		high_speed = 1;
		for (i = 0; i < 3; i++) begin
			up_idle_to_k = 1;
			move(4'h2);
			up_idle_to_k = 0;
			{buffer_drained, send_resume_end, interval_end, receiver_interval_end} =
				(i == 0) ? 4'h8 : (i == 1) ? 4'h6 : 4'h1;
			stay;
			buffer_last_bit_sent = 1;
			move(4'h4);
			{buffer_drained, send_resume_end, interval_end, receiver_interval_end} = 0;
			buffer_last_bit_sent = 0;
		end
		$display("test high-speed end done");
		tick(20);
		hold = 1;
		for (i = 0; i < 9; i++) begin
			up_idle_to_k = 1;
			move(4'h2);
			{up_idle_to_k, buffer_drained, buffer_last_bit_sent} = 3'b011;
			move(4'h4);
			{buffer_drained, buffer_last_bit_sent} = 0;
		end
		chk_out({3'h0, evt_overflow}, 4'h1);
		hold = 0;
		tick(60);
		chk_out({3'h0, exp_q.size() == 0}, 4'h1);
		$display("test event log done");
		test_done;
	end
endmodule
